// ---- verilog/bertcs_pkg.sv ----
// bit-error tester control/status: register map, field positions, modes
// assumes an 8-bit register port and bit-rate enables synchronous to clk_sys
//
// Overview of operation
// - rx invert bit set inverts every received bit before pattern checking; zero/one run detection sees the raw bit
// - tx invert bit set inverts every generated bit before sending
// - rising edge of pattern load bit reloads generator from pattern set
// - repeat length code means pattern length minus 17, 17 to 32 bits
// - checker ignores repeat length code for pseudorandom patterns
// - each rising edge of single-error bit corrupts exactly one sent bit
// - error rate code 1..7 inserts errors one in ten to ten million
// - sync set after 32 matching bits; status flags both edges
// - loss-of-sync flag set when search starts, held until read
// - all-zeros flag set after 32 zeros, cannot clear while zeros persist
// - all-ones flag set after 32 ones, cannot clear while ones persist
// - error counter overflow latches, clears on read, sets again only anew
// - bit counter overflow latches, clears on read, sets again only anew
// - bit-error flag set per error seen in sync, cleared on read
// - mask bit one enables source; conditions flag on both edges
// - alternating words each repeat word-count times, then swap
// - pattern select decodes the eight pattern kinds
// - rising edge of latch bit snapshots counts and clears counters
// - bit counter counts every bit in sync and saturates when full
`default_nettype none
package bertcs_pkg;
  // ***************
  // register map
  // ***************
  localparam logic [7:0] ADDR_STATUS = 8'h26;
  localparam logic [7:0] ADDR_MASK = 8'h27;
  localparam logic [7:0] ADDR_INFO = 8'h28;
  localparam logic [7:0] ADDR_AWC = 8'hDB;
  localparam logic [7:0] ADDR_PAT0 = 8'hDC;
  localparam logic [7:0] ADDR_CTRL1 = 8'hE0;
  localparam logic [7:0] ADDR_CTRL2 = 8'hE1;
  localparam logic [7:0] ADDR_BITCNT0 = 8'hE3;
  localparam logic [7:0] ADDR_ERRCNT0 = 8'hE7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ***************
  // fields
  // ***************
  localparam int C1_RESYNC = 0;
  localparam int C1_LATCH = 1;
  localparam int C1_PSEL = 2;
  localparam int C1_RXINV = 5;
  localparam int C1_TXINV = 6;
  localparam int C1_LOAD = 7;
  localparam int C2_RLEN = 0;
  localparam int C2_SBE = 4;
  localparam int C2_RATE = 5;
  localparam int ST_W = 7;
  localparam int ST_SYNC = 0;
  localparam int ST_ECO = 4;
  localparam int ST_BCO = 5;
  localparam int ST_BED = 6;
  // ***************
  // stream constants
  // ***************
  localparam logic [5:0] SYNC_RUN = 6'h20;
  localparam logic [2:0] LOSS_ERRS = 3'h4;
  localparam logic [4:0] REP_BASE_M1 = 5'h10;
  localparam logic [4:0] FULL_M1 = 5'h1F;
  localparam logic [3:0] WORD_LAST = 4'hF;
  localparam logic [31:0] BIT_MAX = 32'hFFFF_FFFF;
  localparam logic [23:0] ERR_MAX = 24'hFF_FFFF;
  typedef enum logic [2:0] {
    PAT_PRBS7, PAT_PRBS11, PAT_PRBS15, PAT_QRSS,
    PAT_REPEAT, PAT_ALTWORD, PAT_DALY, PAT_PRBS9
  } bertcs_pat_t;
  typedef enum logic {CHK_SEARCH, CHK_SYNC} bertcs_chk_t;
endpackage
`default_nettype wire

// ---- verilog/bertcs_pat_mem.sv ----
// pattern set storage: small word memory, contents come straight from flops
// assumes writes are single-cycle strobes from the register port
`default_nettype none
module bertcs_pat_mem #(
  parameter int WORDS = 4,
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [$clog2(WORDS)-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WORDS*WIDTH-1:0] words
);
  localparam int IDX_W = $clog2(WORDS);
  logic [WIDTH-1:0] mem [WORDS];
  if (WORDS < 2 || WIDTH < 1) begin : g_bad
    $error("pattern memory needs at least two words");
  end
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        mem[i] <= '0;
      end else if (wrEn && wrIdx == IDX_W'(i)) begin
        mem[i] <= wrData;
      end
    end
    assign words[i*WIDTH +: WIDTH] = mem[i];
  end
endmodule
`default_nettype wire

// ---- verilog/bertcs_top.sv ----
// bit-error tester control and status: pattern generator, checker, flags
// assumes bit enables one cycle wide and synchronous to clk_sys
`default_nettype none
module bertcs_top #(
  parameter int RATE_SCALE = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic txBitEn,
  output logic txData,
  input wire logic rxBitEn,
  input wire logic rxData,
  output logic irq
);
  if (RATE_SCALE < 2 || RATE_SCALE > 10) begin : g_bad
    $error("rate scale must lie in 2..10");
  end
  // ***************
  // helpers
  // ***************
  function automatic logic isPrbs(input bertcs_pkg::bertcs_pat_t p);
    return p inside {bertcs_pkg::PAT_PRBS7, bertcs_pkg::PAT_PRBS11, bertcs_pkg::PAT_PRBS15,
                     bertcs_pkg::PAT_QRSS, bertcs_pkg::PAT_PRBS9};
  endfunction
  // feedback taps, zero based: upper five bits and lower five bits
  function automatic logic [9:0] prbsTaps(input bertcs_pkg::bertcs_pat_t p);
    case (p)
      bertcs_pkg::PAT_PRBS7: return {5'h06, 5'h05};
      bertcs_pkg::PAT_PRBS11: return {5'h0A, 5'h08};
      bertcs_pkg::PAT_PRBS15: return {5'h0E, 5'h0D};
      bertcs_pkg::PAT_QRSS: return {5'h13, 5'h10};
      bertcs_pkg::PAT_PRBS9: return {5'h08, 5'h04};
      default: return 10'h000;
    endcase
  endfunction
  function automatic logic [31:0] rotate(input logic [31:0] v, input logic [4:0] last);
    logic [31:0] r;
    r = {1'b0, v[31:1]};
    r[last] = v[0];
    return r;
  endfunction
  function automatic logic [23:0] ratePeriod(input logic [2:0] code);
    logic [23:0] p;
    p = 24'h00_0001;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(code)) begin
        p = 24'(p * RATE_SCALE);
      end
    end
    return p;
  endfunction
  // ***************
  // registers
  // ***************
  logic [7:0] ctrlOne;
  logic [7:0] ctrlTwo;
  logic [7:0] ctrlOnePrev;
  logic [7:0] ctrlTwoPrev;
  logic [7:0] wordCount;
  logic [bertcs_pkg::ST_W-1:0] status;
  logic [bertcs_pkg::ST_W-1:0] mask;
  logic [31:0] pattern;
  logic patWr;
  assign patWr = regWr && regAddr[7:2] == bertcs_pkg::ADDR_PAT0[7:2];
  bertcs_pat_mem #(.WORDS(4), .WIDTH(8)) u_pat (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(patWr),
    .wrIdx(regAddr[1:0]),
    .wrData(regWrData),
    .words(pattern)
  );
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrlOne <= bertcs_pkg::RESET_BYTE;
      ctrlTwo <= bertcs_pkg::RESET_BYTE;
      wordCount <= bertcs_pkg::RESET_BYTE;
      mask <= '0;
    end else if (regWr) begin
      case (regAddr)
        bertcs_pkg::ADDR_CTRL1: ctrlOne <= regWrData;
        bertcs_pkg::ADDR_CTRL2: ctrlTwo <= regWrData;
        bertcs_pkg::ADDR_AWC: wordCount <= regWrData;
        bertcs_pkg::ADDR_MASK: mask <= regWrData[bertcs_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrlOnePrev <= bertcs_pkg::RESET_BYTE;
      ctrlTwoPrev <= bertcs_pkg::RESET_BYTE;
    end else begin
      ctrlOnePrev <= ctrlOne;
      ctrlTwoPrev <= ctrlTwo;
    end
  end
  // only edges act, so a bit left high does nothing more
  logic loadRise;
  logic sbeRise;
  logic resyncRise;
  logic latchRise;
  assign loadRise = ctrlOne[bertcs_pkg::C1_LOAD] & ~ctrlOnePrev[bertcs_pkg::C1_LOAD];
  assign sbeRise = ctrlTwo[bertcs_pkg::C2_SBE] & ~ctrlTwoPrev[bertcs_pkg::C2_SBE];
  assign resyncRise = ctrlOne[bertcs_pkg::C1_RESYNC] & ~ctrlOnePrev[bertcs_pkg::C1_RESYNC];
  assign latchRise = ctrlOne[bertcs_pkg::C1_LATCH] & ~ctrlOnePrev[bertcs_pkg::C1_LATCH];
  bertcs_pkg::bertcs_pat_t patSel;
  logic [4:0] lenM1;
  logic [9:0] taps;
  logic [2:0] rateCode;
  assign patSel = bertcs_pkg::bertcs_pat_t'(ctrlOne[bertcs_pkg::C1_PSEL +: 3]);
  assign lenM1 = bertcs_pkg::REP_BASE_M1 + {1'b0, ctrlTwo[bertcs_pkg::C2_RLEN +: 4]};
  assign taps = prbsTaps(patSel);
  assign rateCode = ctrlTwo[bertcs_pkg::C2_RATE +: 3];
  // ***************
  // generator
  // ***************
  logic [31:0] genShift;
  logic [31:0] next_genShift;
  logic genBit;
  logic [3:0] altBit;
  logic [7:0] altRep;
  logic altSel;
  always_comb begin
    next_genShift = genShift;
    genBit = 1'b0;
    if (isPrbs(patSel)) begin
      genBit = genShift[taps[9:5]] ^ genShift[taps[4:0]];
      next_genShift = {genShift[30:0], genBit};
    end else if (patSel == bertcs_pkg::PAT_ALTWORD) begin
      genBit = pattern[{altSel, altBit}];
    end else begin
      // daly runs as a full 32-bit repeat of the pattern set
      genBit = genShift[0];
      next_genShift = rotate(genShift, patSel == bertcs_pkg::PAT_REPEAT ? lenM1
                                                               : bertcs_pkg::FULL_M1);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      genShift <= '0;
    end else if (loadRise) begin
      genShift <= pattern;
    end else if (txBitEn) begin
      genShift <= next_genShift;
    end
  end
  // count of zero means 256 repeats through the 8-bit wrap
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      altBit <= '0;
      altRep <= '0;
      altSel <= 1'b0;
    end else if (loadRise) begin
      altBit <= '0;
      altRep <= '0;
      altSel <= 1'b0;
    end else if (txBitEn && patSel == bertcs_pkg::PAT_ALTWORD) begin
      altBit <= altBit + 4'h1;
      if (altBit == bertcs_pkg::WORD_LAST) begin
        if (altRep + 8'h01 == wordCount) begin
          altRep <= '0;
          altSel <= ~altSel;
        end else begin
          altRep <= altRep + 8'h01;
        end
      end
    end
  end
  // ***************
  // error insertion and tx output
  // ***************
  logic [23:0] rateCnt;
  logic rateHit;
  logic sbePending;
  assign rateHit = rateCode != 3'h0 && rateCnt == ratePeriod(rateCode) - 24'h00_0001;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rateCnt <= '0;
    end else if (rateCode == 3'h0) begin
      rateCnt <= '0;
    end else if (txBitEn) begin
      rateCnt <= rateHit ? 24'h00_0000 : rateCnt + 24'h00_0001;
    end
  end
  // a new request in the cycle that consumes the old one survives
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sbePending <= 1'b0;
    end else begin
      sbePending <= sbeRise | (sbePending & ~txBitEn);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txData <= 1'b0;
    end else if (txBitEn) begin
      txData <= genBit ^ (sbePending | rateHit) ^ ctrlOne[bertcs_pkg::C1_TXINV];
    end
  end
  // ***************
  // checker
  // ***************
  logic rxBit;
  logic expBit;
  logic bitMatch;
  logic [31:0] rxHist;
  bertcs_pkg::bertcs_chk_t chkState;
  logic [5:0] matchCnt;
  logic [2:0] badCnt;
  logic inSync;
  assign rxBit = rxData ^ ctrlOne[bertcs_pkg::C1_RXINV];
  // self-synchronising for pseudorandom, so the length code plays no part
  assign expBit = isPrbs(patSel) ? rxHist[taps[9:5]] ^ rxHist[taps[4:0]]
                : rxHist[patSel == bertcs_pkg::PAT_REPEAT ? lenM1 : bertcs_pkg::FULL_M1];
  assign bitMatch = rxBit == expBit;
  assign inSync = chkState == bertcs_pkg::CHK_SYNC;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxHist <= '0;
    end else if (rxBitEn) begin
      rxHist <= {rxHist[30:0], rxBit};
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chkState <= bertcs_pkg::CHK_SEARCH;
      matchCnt <= '0;
      badCnt <= '0;
    end else if (resyncRise) begin
      chkState <= bertcs_pkg::CHK_SEARCH;
      matchCnt <= '0;
      badCnt <= '0;
    end else if (rxBitEn) begin
      unique case (chkState)
        bertcs_pkg::CHK_SEARCH: begin
          if (!bitMatch) begin
            matchCnt <= '0;
          end else if (matchCnt == bertcs_pkg::SYNC_RUN - 6'h01) begin
            chkState <= bertcs_pkg::CHK_SYNC;
            matchCnt <= '0;
          end else begin
            matchCnt <= matchCnt + 6'h01;
          end
        end
        bertcs_pkg::CHK_SYNC: begin
          if (!bitMatch) begin
            matchCnt <= '0;
            badCnt <= badCnt + 3'h1;
            if (badCnt == bertcs_pkg::LOSS_ERRS - 3'h1) begin
              chkState <= bertcs_pkg::CHK_SEARCH;
              badCnt <= '0;
            end
          end else if (matchCnt == bertcs_pkg::SYNC_RUN - 6'h01) begin
            matchCnt <= '0;
            badCnt <= '0;
          end else begin
            matchCnt <= matchCnt + 6'h01;
          end
        end
      endcase
    end
  end
  // ***************
  // runs and counters
  // ***************
  logic [5:0] zeroRun;
  logic [5:0] oneRun;
  logic allZeros;
  logic allOnes;
  assign allZeros = zeroRun == bertcs_pkg::SYNC_RUN;
  assign allOnes = oneRun == bertcs_pkg::SYNC_RUN;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zeroRun <= '0;
      oneRun <= '0;
    end else if (rxBitEn) begin
      zeroRun <= rxData ? 6'h00 : (allZeros ? zeroRun : zeroRun + 6'h01);
      oneRun <= !rxData ? 6'h00 : (allOnes ? oneRun : oneRun + 6'h01);
    end
  end
  logic [31:0] bitCnt;
  logic [31:0] bitSnap;
  logic [23:0] errCnt;
  logic [23:0] errSnap;
  logic errDetected;
  logic bitOvf;
  logic errOvf;
  assign errDetected = rxBitEn && inSync && !bitMatch;
  assign bitOvf = rxBitEn && inSync && !latchRise
                  && bitCnt == bertcs_pkg::BIT_MAX - 32'h0000_0001;
  assign errOvf = errDetected && !latchRise
                  && errCnt == bertcs_pkg::ERR_MAX - 24'h00_0001;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt <= '0;
      errCnt <= '0;
      bitSnap <= '0;
      errSnap <= '0;
    end else if (latchRise) begin
      bitSnap <= bitCnt;
      errSnap <= errCnt;
      bitCnt <= '0;
      errCnt <= '0;
    end else begin
      if (rxBitEn && inSync && bitCnt != bertcs_pkg::BIT_MAX) begin
        bitCnt <= bitCnt + 32'h0000_0001;
      end
      if (errDetected && errCnt != bertcs_pkg::ERR_MAX) begin
        errCnt <= errCnt + 24'h00_0001;
      end
    end
  end
  // ***************
  // status, interrupt
  // ***************
  logic [3:0] cond;
  logic [3:0] condPrev;
  logic [bertcs_pkg::ST_W-1:0] stSet;
  logic [bertcs_pkg::ST_W-1:0] stClr;
  logic stRead;
  assign cond = {allOnes, allZeros, ~inSync, inSync};
  assign stRead = regRd && regAddr == bertcs_pkg::ADDR_STATUS;
  // conditions flag on both edges; sync loss starts a search, its rise
  assign stSet = {errDetected, bitOvf, errOvf, cond ^ condPrev};
  // a run still present refuses the clear
  assign stClr = stRead ? ~{3'b000, allOnes, allZeros, 2'b00} : '0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      condPrev <= 4'h0;
    end else begin
      condPrev <= cond;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status <= (status & ~stClr) | stSet;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end
  // ***************
  // read port
  // ***************
  logic [7:0] next_regRdData;
  always_comb begin
    next_regRdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        bertcs_pkg::ADDR_STATUS: next_regRdData = {1'b0, status};
        bertcs_pkg::ADDR_MASK: next_regRdData = {1'b0, mask};
        bertcs_pkg::ADDR_INFO: next_regRdData = {4'h0, cond};
        bertcs_pkg::ADDR_AWC: next_regRdData = wordCount;
        bertcs_pkg::ADDR_CTRL1: next_regRdData = ctrlOne;
        bertcs_pkg::ADDR_CTRL2: next_regRdData = ctrlTwo;
        bertcs_pkg::ADDR_BITCNT0: next_regRdData = bitSnap[7:0];
        bertcs_pkg::ADDR_BITCNT0 + 8'h01: next_regRdData = bitSnap[15:8];
        bertcs_pkg::ADDR_BITCNT0 + 8'h02: next_regRdData = bitSnap[23:16];
        bertcs_pkg::ADDR_BITCNT0 + 8'h03: next_regRdData = bitSnap[31:24];
        bertcs_pkg::ADDR_ERRCNT0: next_regRdData = errSnap[7:0];
        bertcs_pkg::ADDR_ERRCNT0 + 8'h01: next_regRdData = errSnap[15:8];
        bertcs_pkg::ADDR_ERRCNT0 + 8'h02: next_regRdData = errSnap[23:16];
        default: begin
          if (regAddr[7:2] == bertcs_pkg::ADDR_PAT0[7:2]) begin
            next_regRdData = pattern[{regAddr[1:0], 3'b000} +: 8];
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end
  // ***************
  // assertions
  // ***************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence s_load_edge;
    !ctrlOne[bertcs_pkg::C1_LOAD] ##1 ctrlOne[bertcs_pkg::C1_LOAD];
  endsequence
  property p_rx_inv;
    rxBitEn |=> rxHist[0] == $past(rxData ^ ctrlOne[bertcs_pkg::C1_RXINV]);
  endproperty
  a_rx_inv: assert property (p_rx_inv) else $error("rx bit not inverted as set");
  property p_tx_inv;
    txBitEn && !sbePending && !rateHit
      |=> txData == $past(genBit ^ ctrlOne[bertcs_pkg::C1_TXINV]);
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("tx bit polarity wrong");
  property p_load;
    s_load_edge |=> genShift == $past(pattern);
  endproperty
  a_load: assert property (p_load) else $error("generator not loaded on edge");
  property p_sbe;
    sbeRise ##0 (!txBitEn [*2]) |-> sbePending;
  endproperty
  a_sbe: assert property (p_sbe) else $error("single error request lost");
  property p_sync;
    chkState == bertcs_pkg::CHK_SEARCH && rxBitEn && bitMatch && !resyncRise
      && matchCnt == 6'h1F |=> inSync ##1 status[bertcs_pkg::ST_SYNC];
  endproperty
  a_sync: assert property (p_sync) else $error("sync not reached after full run");
  property p_zero_hold;
    allZeros && stRead |=> status[2];
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("all-zeros cleared too early");
  property p_ovf;
    errOvf |=> status[bertcs_pkg::ST_ECO] && errCnt == bertcs_pkg::ERR_MAX;
  endproperty
  a_ovf: assert property (p_ovf) else $error("error overflow not latched");
  property p_bed;
    $rose(status[bertcs_pkg::ST_BED]) |-> $past(inSync);
  endproperty
  a_bed: assert property (p_bed) else $error("bit error flagged out of sync");
  property p_irq;
    ##1 irq == $past(|(status & mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow mask");
  property p_bitcnt;
    rxBitEn && inSync && !latchRise && bitCnt != bertcs_pkg::BIT_MAX
      |=> bitCnt == $past(bitCnt) + 32'h0000_0001;
  endproperty
  a_bitcnt: assert property (p_bitcnt) else $error("bit counter missed a bit");
  property p_latch;
    latchRise |=> bitCnt == 32'h0000_0000 && bitSnap == $past(bitCnt);
  endproperty
  a_latch: assert property (p_latch) else $error("counter snapshot wrong");
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the bit-error tester control and status block
// assumes bertcs_pkg and bertcs_top are compiled first; bench drives all ports itself
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ***************
  // stimulus and design
  // ***************
  localparam logic [31:0] PAT = 32'hA5C3_1E69;
  localparam int AWC = 2;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic txBitEn = 1'b0;
  logic txData;
  logic rxBitEn = 1'b0;
  logic rxData = 1'b0;
  logic irq;
  int nErrors = 0;
  int numChecks = 0;
  int rxIdx = 0;
  // short insertion periods keep the rate scenario brief
  bertcs_top #(.RATE_SCALE(2)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .txBitEn(txBitEn), .txData(txData), .rxBitEn(rxBitEn), .rxData(rxData), .irq(irq));
  always #50 clk_sys = ~clk_sys;
  // ***************
  // shared tasks
  // ***************
  task automatic summarize();
    if (nErrors == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic txBit(output logic b);
    @(posedge clk_sys);
    txBitEn <= 1'b1;
    @(posedge clk_sys);
    txBitEn <= 1'b0;
    #1 b = txData;
  endtask
  task automatic rxBit(input logic b);
    @(posedge clk_sys);
    rxBitEn <= 1'b1;
    rxData <= b;
    @(posedge clk_sys);
    rxBitEn <= 1'b0;
  endtask
  // load bit cleared first so every run sees a fresh rising edge
  task automatic txRun(input int n, input int len, input logic [7:0] sel, output int bad);
    logic b;
    logic e;
    int w;
    bad = 0;
    wr(bertcs_pkg::ADDR_CTRL1, sel);
    wr(bertcs_pkg::ADDR_CTRL1, sel | 8'h80);
    for (int i = 0; i < n; i++) begin
      txBit(b);
      w = ((i / 16) / AWC) % 2;
      e = sel[2] ? PAT[16 * w + i % 16] : PAT[i % len];
      if (b !== (e ^ sel[6])) bad++;
    end
  endtask
  // rx invert is on, so the line carries the inverted pattern; errors on even bits
  task automatic rxRun(input int n, input int nErr);
    for (int i = 0; i < n; i++) begin
      rxBit(~PAT[rxIdx % 32] ^ (i < 2 * nErr && i % 2 == 0));
      rxIdx++;
    end
  endtask
  // ***************
  // scenarios
  // ***************
  task automatic regScen();
    logic [7:0] d;
    logic [7:0] addrs[4] = '{8'h27, 8'hDB, 8'hE0, 8'hE1};
    foreach (addrs[k]) begin
      rd(addrs[k], d);
      chk(d, 8'h00);
    end
    wr(8'h27, 8'hFF);
    rd(8'h27, d);
    chk(d, 8'h7F);
    wr(8'h27, 8'h00);
    wr(bertcs_pkg::ADDR_AWC, 8'(AWC));
    rd(bertcs_pkg::ADDR_AWC, d);
    chk(d, 8'h02);
    rd(8'h00, d);
    chk(d, 8'h00);
    for (int k = 0; k < 4; k++) wr(bertcs_pkg::ADDR_PAT0 + 8'(k), PAT[8 * k +: 8]);
  endtask
  task automatic txScen();
    int bad;
    wr(bertcs_pkg::ADDR_CTRL2, 8'h00);
    txRun(40, 17, 8'h10, bad);
    chk(32'(bad), 32'h0);
    wr(bertcs_pkg::ADDR_CTRL2, 8'h0F);
    txRun(40, 32, 8'h50, bad);
    chk(32'(bad), 32'h0);
    txRun(80, 32, 8'h14, bad);
    chk(32'(bad), 32'h0);
    wr(bertcs_pkg::ADDR_CTRL2, 8'h1F);
    txRun(40, 32, 8'h10, bad);
    chk(32'(bad), 32'h1);
    txRun(40, 32, 8'h10, bad);
    chk(32'(bad), 32'h0);
    for (int c = 1; c < 4; c++) begin
      wr(bertcs_pkg::ADDR_CTRL2, 8'(c << 5) | 8'h0F);
      txRun(64, 32, 8'h10, bad);
      chk(32'(bad >= (64 >> c) - 1 && bad <= (64 >> c) + 1), 32'h1);
    end
    wr(bertcs_pkg::ADDR_CTRL2, 8'h0F);
    txRun(64, 32, 8'h10, bad);
    chk(32'(bad), 32'h0);
  endtask
  task automatic rxScen();
    logic [7:0] d;
    wr(bertcs_pkg::ADDR_CTRL1, 8'h30);
    rxRun(64, 0);
    rd(bertcs_pkg::ADDR_INFO, d);
    chk(d, 8'h01);
    rd(bertcs_pkg::ADDR_STATUS, d);
    chk(d, 8'h03);
    wr(bertcs_pkg::ADDR_MASK, 8'h40);
    rxRun(1, 1);
    rxRun(8, 0);
    chk(irq, 1'b1);
    rd(bertcs_pkg::ADDR_STATUS, d);
    chk(d, 8'h40);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    rxRun(8, 4);
    rxRun(64, 0);
    rd(bertcs_pkg::ADDR_STATUS, d);
    chk(d, 8'h43);
    rd(bertcs_pkg::ADDR_STATUS, d);
    chk(d, 8'h00);
  endtask
  task automatic runScen();
    logic [7:0] d;
    logic [7:0] f;
    for (int lvl = 0; lvl < 2; lvl++) begin
      f = 8'h04 << lvl;
      wr(bertcs_pkg::ADDR_MASK, f);
      repeat (32) rxBit(lvl[0]);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b1);
      rd(bertcs_pkg::ADDR_STATUS, d);
      chk(d & f, f);
      rd(bertcs_pkg::ADDR_STATUS, d);
      chk(d & f, f);
      wr(bertcs_pkg::ADDR_MASK, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0);
      rxBit(~lvl[0]);
      repeat (3) @(posedge clk_sys);
      rd(bertcs_pkg::ADDR_STATUS, d);
      chk(d & f, f);
      rd(bertcs_pkg::ADDR_STATUS, d);
      chk(d & f, 8'h00);
    end
  endtask
  // 7-bit pseudorandom stream looped back to the checker; a short length code proves it unused
  task automatic prbsScen();
    logic [95:0] h;
    logic [7:0] d;
    logic b;
    int bad;
    bad = 0;
    h = '0;
    wr(bertcs_pkg::ADDR_CTRL2, 8'h00);
    for (int k = 0; k < 4; k++) wr(bertcs_pkg::ADDR_PAT0 + 8'(k), 8'hFF);
    wr(bertcs_pkg::ADDR_CTRL1, 8'h00);
    wr(bertcs_pkg::ADDR_CTRL1, 8'h80);
    for (int i = 0; i < 96; i++) begin
      txBit(b);
      h[i] = b;
      if (i >= 7 && h[i] !== (h[i - 7] ^ h[i - 6])) bad++;
    end
    chk(32'(bad), 32'h0);
    for (int i = 0; i < 64; i++) rxBit(h[i]);
    rd(bertcs_pkg::ADDR_INFO, d);
    chk(d, 8'h01);
    wr(bertcs_pkg::ADDR_CTRL1, 8'h82);
    wr(bertcs_pkg::ADDR_CTRL1, 8'h80);
    for (int i = 64; i < 96; i++) rxBit(h[i]);
    wr(bertcs_pkg::ADDR_CTRL1, 8'h82);
    rd(bertcs_pkg::ADDR_BITCNT0, d);
    chk(d, 8'h20);
    rd(bertcs_pkg::ADDR_ERRCNT0, d);
    chk(d, 8'h00);
  endtask
  // ***************
  // sequence and watchdog
  // ***************
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    regScen();
    txScen();
    rxScen();
    runScen();
    prbsScen();
    summarize();
  end
  // the tests need about two thousand cycles; the 50000-cycle limit lies well above that
  initial begin
    repeat (50000) @(posedge clk_sys);
    nErrors++;
    summarize();
  end
endmodule
`default_nettype wire
